// ### stop_mode_defines.svh
`ifndef STOP_MODE_DEFINES_SVH
`define STOP_MODE_DEFINES_SVH

// Register offsets.
`define HALT_CONTROL_ADDR       8'h38
`define CLOCK_MODE_CONTROL_ADDR 8'h39

// Halt control fields.
`define HC_HALT_BIT    7
`define HC_RELEASE_METHOD_BIT    6
`define HC_RETURN_MODE_SELECT_BIT    5
`define HC_KEEP_BIT    4
`define HC_WUT_HI      3
`define HC_WUT_LO      2

// Clock mode control fields.
`define CM_FAST_BIT    7
`define CM_SLOW_BIT    6
`define CM_SEL_BIT     5
`define CM_IDLE_BIT    4
`define CM_GATE_BIT    2

// Reset values.
`define HALT_CONTROL_RST       8'h00
`define CLOCK_MODE_CONTROL_RST 8'h80

// Warm-up counts in oscillator cycles.
`define WU_FAST_0 32'h0003_0000
`define WU_FAST_1 32'h0001_0000
`define WU_FAST_2 32'h0000_C000
`define WU_FAST_3 32'h0000_4000
`define WU_SLOW_0 32'h0000_6000
`define WU_SLOW_1 32'h0000_2000
`define WU_SLOW_2 32'h0000_00C0
`define WU_SLOW_3 32'h0000_0040
`define FLASH_WAIT_FAST 32'h0000_0400
`define FLASH_WAIT_SLOW 32'h0000_0008

`endif

// ### stop_mode_pkg.sv
package stop_mode_pkg;

  typedef enum logic [1:0] {
    PM_RUN,
    PM_HALT,
    PM_WARMUP,
    PM_FLASH_WAIT
  } power_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic fast_osc_on;
    logic slow_osc_on;
    logic slow_clock_active;
    logic cpu_halt;
    logic wdt_halt;
    logic periph_gate;
    logic tg_clear;
  } clk_ctrl_t;

endpackage : stop_mode_pkg

// ### stop_mode_power_control.sv
`timescale 1ns/1ns
`include "stop_mode_defines.svh"
module stop_mode_power_control
  import stop_mode_pkg::*;
#(
  parameter int CNT_W = 32,
  parameter logic [CNT_W-1:0] WU_FAST_0_CYC = `WU_FAST_0,
  parameter logic [CNT_W-1:0] WU_FAST_1_CYC = `WU_FAST_1,
  parameter logic [CNT_W-1:0] WU_FAST_2_CYC = `WU_FAST_2,
  parameter logic [CNT_W-1:0] WU_FAST_3_CYC = `WU_FAST_3,
  parameter logic [CNT_W-1:0] WU_SLOW_0_CYC = `WU_SLOW_0,
  parameter logic [CNT_W-1:0] WU_SLOW_1_CYC = `WU_SLOW_1,
  parameter logic [CNT_W-1:0] WU_SLOW_2_CYC = `WU_SLOW_2,
  parameter logic [CNT_W-1:0] WU_SLOW_3_CYC = `WU_SLOW_3
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Register port
  input  wire reg_req_t   req,
  output logic [7:0]      rdata,
  // Oscillator ticks, one-cycle pulses on sys_clk
  input  wire logic       fast_tick,
  input  wire logic       slow_tick,
  // Wake pins
  input  wire logic       release_pin_port,
  input  wire logic [3:0] key_wake_inputs,
  input  wire logic [3:0] key_wake_control,
  // Flash wait enable
  input  wire logic       halt_flash_wait_enable,
  // Idle and deep idle release event
  input  wire logic       idle_release,
  // Clock control outputs
  output clk_ctrl_t       clk_ctrl,
  output logic            port_float,
  output logic            port_input_zero,
  output logic            release_pin_float,
  output logic            pc_hold,
  output logic            soft_reset_req
);

  logic [7:0]       halt_control_reg;
  logic [7:0]       clock_mode_control_reg;
  logic [7:0]       rdata_reg;
  power_state_t     state_reg;
  power_state_t     state_next;
  logic [CNT_W-1:0] count_reg;
  logic [1:0]       rel_sync_reg;
  logic [3:0]       key_sync0_reg;
  logic [3:0]       key_sync_reg;
  logic             rel_prev_reg;
  logic             level_armed_reg;
  logic             target_slow_reg;
  logic             flash_wait_reg;
  logic             soft_reset_reg;

  // Pin synchronisers; only stage two is ever read.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rel_sync_reg  <= 2'h0;
      key_sync0_reg <= 4'hF;
      key_sync_reg  <= 4'hF;
      rel_prev_reg  <= 1'b0;
    end else begin
      rel_sync_reg  <= {rel_sync_reg[0], release_pin_port};
      key_sync0_reg <= key_wake_inputs;
      key_sync_reg  <= key_sync0_reg;
      rel_prev_reg  <= rel_sync_reg[1];
    end
  end

  wire rel_level = rel_sync_reg[1];
  wire rel_rise  = rel_level & ~rel_prev_reg;
  wire key_wake  = |(~key_sync_reg & key_wake_control);

  // Register decode.
  wire wr_halt = req.wr && (req.addr == `HALT_CONTROL_ADDR);
  wire wr_mode = req.wr && (req.addr == `CLOCK_MODE_CONTROL_ADDR);
  wire rd_halt = req.rd && (req.addr == `HALT_CONTROL_ADDR);
  wire rd_mode = req.rd && (req.addr == `CLOCK_MODE_CONTROL_ADDR);

  wire release_method_level   = halt_control_reg[`HC_RELEASE_METHOD_BIT];
  wire ret_slow     = halt_control_reg[`HC_RETURN_MODE_SELECT_BIT];
  wire [1:0] warmup_select    = halt_control_reg[`HC_WUT_HI:`HC_WUT_LO];
  wire halt_start   = wr_halt && req.wdata[`HC_HALT_BIT] && (state_reg == PM_RUN);

  // Level release counts only once armed after a mode change.
  wire level_mode   = release_method_level && level_armed_reg;
  wire level_wake   = rel_level | key_wake;
  wire wake_now     = level_mode ? level_wake : rel_rise;

  // Selected warm-up length for the mode being returned to.
  wire new_slow     = req.wdata[`HC_RETURN_MODE_SELECT_BIT];
  logic [CNT_W-1:0] wu_fast_sel;
  logic [CNT_W-1:0] wu_slow_sel;
  logic [CNT_W-1:0] wu_target;
  assign wu_fast_sel = (warmup_select == 2'h0) ? WU_FAST_0_CYC :
                       (warmup_select == 2'h1) ? WU_FAST_1_CYC :
                       (warmup_select == 2'h2) ? WU_FAST_2_CYC : WU_FAST_3_CYC;
  assign wu_slow_sel = (warmup_select == 2'h0) ? WU_SLOW_0_CYC :
                       (warmup_select == 2'h1) ? WU_SLOW_1_CYC :
                       (warmup_select == 2'h2) ? WU_SLOW_2_CYC : WU_SLOW_3_CYC;
  assign wu_target   = target_slow_reg ? wu_slow_sel : wu_fast_sel;
  wire [CNT_W-1:0] fw_target = target_slow_reg ? CNT_W'(`FLASH_WAIT_SLOW) :
                                                 CNT_W'(`FLASH_WAIT_FAST);
  wire tick         = target_slow_reg ? slow_tick : fast_tick;
  wire count_done   = (state_reg == PM_WARMUP) ? (count_reg >= wu_target - 1'b1) :
                                                 (count_reg >= fw_target - 1'b1);

  // Oscillator-enable combinations that are illegal force a reset.
  wire [7:0] wd = req.wdata;
  wire osc_fault = wr_mode && ((~wd[`CM_FAST_BIT] && ~wd[`CM_SLOW_BIT]) ||
                   (~wd[`CM_FAST_BIT] && ~clock_mode_control_reg[`CM_SEL_BIT]) ||
                   (~wd[`CM_SLOW_BIT] && clock_mode_control_reg[`CM_SEL_BIT]));

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      PM_RUN:
        if (halt_start)
          state_next = (req.wdata[`HC_RELEASE_METHOD_BIT] && level_armed_reg && level_wake) ?
                       PM_WARMUP : PM_HALT;
      PM_HALT:
        if (wake_now)
          state_next = PM_WARMUP;
      PM_WARMUP:
        if (tick && count_done)
          state_next = flash_wait_reg ? PM_FLASH_WAIT : PM_RUN;
      PM_FLASH_WAIT:
        if (tick && count_done)
          state_next = PM_RUN;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg       <= PM_RUN;
      count_reg       <= '0;
      target_slow_reg <= 1'b0;
      flash_wait_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_next != state_reg)
        count_reg <= '0;
      else if ((state_reg == PM_WARMUP || state_reg == PM_FLASH_WAIT) && tick)
        count_reg <= count_reg + 1'b1;
      if (halt_start) begin
        target_slow_reg <= new_slow;
        flash_wait_reg  <= halt_flash_wait_enable;
      end
    end
  end

  // Level mode is armed by a rising edge after leaving edge mode.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      level_armed_reg <= 1'b1;
    else if (wr_halt && req.wdata[`HC_RELEASE_METHOD_BIT] && !release_method_level)
      level_armed_reg <= rel_rise;
    else if (release_method_level && rel_rise)
      level_armed_reg <= 1'b1;
  end

  // Registers; the halt bit reads back while the halt sequence runs.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      halt_control_reg       <= `HALT_CONTROL_RST;
      clock_mode_control_reg <= `CLOCK_MODE_CONTROL_RST;
      soft_reset_reg         <= 1'b0;
    end else begin
      soft_reset_reg <= osc_fault;
      if (wr_halt)
        halt_control_reg <= {req.wdata[7:2], 2'h0};
      else if (state_next == PM_RUN && state_reg != PM_RUN)
        halt_control_reg[`HC_HALT_BIT] <= 1'b0;
      if (state_next == PM_RUN && state_reg != PM_RUN)
        clock_mode_control_reg[`CM_FAST_BIT] <= ~target_slow_reg;
      if (wr_mode) begin
        clock_mode_control_reg <= {wd[7:4], 1'b0, wd[2], 2'h0};
      end else if (idle_release) begin
        clock_mode_control_reg[`CM_IDLE_BIT] <= 1'b0;
        clock_mode_control_reg[`CM_GATE_BIT] <= 1'b0;
      end
    end
  end

  // Read data one cycle after the strobe; undefined bits read as zero.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      rdata_reg <= 8'h00;
    else if (rd_halt)
      rdata_reg <= {halt_control_reg[7:2], 2'h0};
    else if (rd_mode)
      rdata_reg <= {clock_mode_control_reg[7:5], clock_mode_control_reg[4],
                    1'b0, clock_mode_control_reg[2], 2'h0};
    else
      rdata_reg <= 8'h00;
  end
  assign rdata = rdata_reg;

  wire halted   = (state_reg == PM_HALT);
  wire warming  = (state_reg == PM_WARMUP);
  wire stopped  = halted | warming;
  wire sel_slow = clock_mode_control_reg[`CM_SEL_BIT];
  wire dual     = clock_mode_control_reg[`CM_SLOW_BIT];

  // The warm-up oscillators follow the return target; slow return leaves fast off.
  assign clk_ctrl.fast_osc_on = halted ? 1'b0 :
                                warming ? ~target_slow_reg :
                                clock_mode_control_reg[`CM_FAST_BIT];
  assign clk_ctrl.slow_osc_on = halted ? 1'b0 :
                                warming ? (target_slow_reg | dual) : dual;
  assign clk_ctrl.slow_clock_active = sel_slow;
  assign clk_ctrl.cpu_halt    = (state_reg != PM_RUN) |
                                clock_mode_control_reg[`CM_IDLE_BIT];
  assign clk_ctrl.wdt_halt    = stopped | clock_mode_control_reg[`CM_IDLE_BIT];
  assign clk_ctrl.periph_gate = stopped | clock_mode_control_reg[`CM_GATE_BIT];
  assign clk_ctrl.tg_clear    = halted;
  assign port_float           = stopped && !halt_control_reg[`HC_KEEP_BIT];
  assign port_input_zero      = port_float;
  assign release_pin_float    = stopped;
  assign pc_hold              = (state_reg != PM_RUN);
  assign soft_reset_req       = soft_reset_reg;

  // Assertions.
  a_halt_osc_off: assert property (@(posedge sys_clk) disable iff (rst)
    halted |-> !clk_ctrl.fast_osc_on && !clk_ctrl.slow_osc_on)
    else $error("Oscillator running while halted.");
  a_tg_cleared: assert property (@(posedge sys_clk) disable iff (rst)
    halted |-> count_reg == '0 && clk_ctrl.tg_clear)
    else $error("Divider not cleared in halt.");
  a_edge_release: assert property (@(posedge sys_clk) disable iff (rst)
    halted && !level_mode && rel_rise |=> state_reg == PM_WARMUP)
    else $error("Edge did not release halt.");
  a_level_release: assert property (@(posedge sys_clk) disable iff (rst)
    halted && level_mode && level_wake |=> state_reg == PM_WARMUP)
    else $error("Level wake missed.");
  a_level_skip: assert property (@(posedge sys_clk) disable iff (rst)
    halt_start && req.wdata[`HC_RELEASE_METHOD_BIT] && level_armed_reg && level_wake
    |=> state_reg == PM_WARMUP)
    else $error("Halt not skipped.");
  a_port_float: assert property (@(posedge sys_clk) disable iff (rst)
    stopped |-> port_float == !halt_control_reg[`HC_KEEP_BIT] && release_pin_float)
    else $error("Port float wrong in halt.");
  a_pc_hold: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(pc_hold) |-> $past(halt_start))
    else $error("Program counter held without halt.");
  a_osc_fault: assert property (@(posedge sys_clk) disable iff (rst)
    osc_fault |=> soft_reset_req)
    else $error("Illegal oscillator write did not reset.");
  a_idle_clear: assert property (@(posedge sys_clk) disable iff (rst)
    idle_release && !wr_mode |=> !clock_mode_control_reg[`CM_IDLE_BIT])
    else $error("Idle bit not cleared.");
  a_slow_target: assert property (@(posedge sys_clk) disable iff (rst)
    warming && target_slow_reg |-> !clk_ctrl.fast_osc_on)
    else $error("Fast oscillator on for slow return.");

  // Entry into the halt and what stays frozen there.
  a_halt_entry: assert property (@(posedge sys_clk) disable iff (rst)
    halt_start |=> state_reg != PM_RUN)
    else $error("Halt request ignored.");
  a_halt_freeze: assert property (@(posedge sys_clk) disable iff (rst)
    halted |-> clk_ctrl.cpu_halt && clk_ctrl.wdt_halt && clk_ctrl.periph_gate)
    else $error("Operation not frozen in halt.");
  a_pc_stopped: assert property (@(posedge sys_clk) disable iff (rst)
    stopped |-> pc_hold && clk_ctrl.cpu_halt)
    else $error("Program counter not held.");
  a_count_entry: assert property (@(posedge sys_clk) disable iff (rst)
    halt_start |=> count_reg == '0)
    else $error("Divider not cleared on entry.");
  a_edge_only: assert property (@(posedge sys_clk) disable iff (rst)
    halted && !level_mode && !rel_rise |=> halted)
    else $error("Edge mode released without an edge.");

  a_return_fast: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg != PM_RUN && state_next == PM_RUN && !target_slow_reg && !wr_mode
    |=> clock_mode_control_reg[`CM_FAST_BIT])
    else $error("Fast oscillator off after fast return.");
  a_return_slow: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg != PM_RUN && state_next == PM_RUN && target_slow_reg && !wr_mode
    |=> !clock_mode_control_reg[`CM_FAST_BIT])
    else $error("Fast oscillator on after slow return.");

  a_warmup_early: assert property (@(posedge sys_clk) disable iff (rst)
    warming && !(tick && count_done) |=> warming)
    else $error("Warm-up ended early.");
  a_warmup_end: assert property (@(posedge sys_clk) disable iff (rst)
    warming && tick && count_done |=> !warming)
    else $error("Warm-up overran.");
  a_flash_entry: assert property (@(posedge sys_clk) disable iff (rst)
    warming && tick && count_done && flash_wait_reg |=> state_reg == PM_FLASH_WAIT)
    else $error("Flash wait skipped.");
  a_flash_skip: assert property (@(posedge sys_clk) disable iff (rst)
    warming && tick && count_done && !flash_wait_reg |=> state_reg == PM_RUN)
    else $error("Unwanted flash wait.");

  // Reset is checked without the disable so that the reset values themselves are seen.
  a_reset_run: assert property (@(posedge sys_clk)
    rst |-> state_reg == PM_RUN && !pc_hold && clk_ctrl.fast_osc_on && !clk_ctrl.slow_osc_on)
    else $error("Reset did not give fast single-clock run.");
  a_read_low: assert property (@(posedge sys_clk) disable iff (rst)
    $past(req.rd) |-> rdata[1:0] == 2'h0)
    else $error("Undefined low bits not zero.");
  a_read_gap: assert property (@(posedge sys_clk) disable iff (rst)
    $past(rd_mode) |-> !rdata[3])
    else $error("Undefined clock mode bit not zero.");

  a_osc_fast_bit: assert property (@(posedge sys_clk) disable iff (rst)
    !stopped |-> clk_ctrl.fast_osc_on == clock_mode_control_reg[`CM_FAST_BIT])
    else $error("Fast oscillator does not follow its enable.");
  a_osc_slow_bit: assert property (@(posedge sys_clk) disable iff (rst)
    !stopped |-> clk_ctrl.slow_osc_on == clock_mode_control_reg[`CM_SLOW_BIT])
    else $error("Slow oscillator does not follow its enable.");
  a_clock_report: assert property (@(posedge sys_clk) disable iff (rst)
    wr_mode |=> clk_ctrl.slow_clock_active == $past(req.wdata[`CM_SEL_BIT]))
    else $error("Clock select not reported.");
  a_gate_clear: assert property (@(posedge sys_clk) disable iff (rst)
    idle_release && !wr_mode |=> !clock_mode_control_reg[`CM_GATE_BIT])
    else $error("Gate bit not cleared.");
  a_legal_write: assert property (@(posedge sys_clk) disable iff (rst)
    wr_mode && !osc_fault |=> !soft_reset_req)
    else $error("Legal oscillator write caused a reset.");

  a_level_disarm: assert property (@(posedge sys_clk) disable iff (rst)
    wr_halt && req.wdata[`HC_RELEASE_METHOD_BIT] && !release_method_level && !rel_rise |=> !level_armed_reg)
    else $error("Level mode armed without an edge.");
  a_level_rearm: assert property (@(posedge sys_clk) disable iff (rst)
    release_method_level && rel_rise && !wr_halt |=> level_armed_reg)
    else $error("Level mode not armed by an edge.");
  a_edge_start: assert property (@(posedge sys_clk) disable iff (rst)
    halt_start && !req.wdata[`HC_RELEASE_METHOD_BIT] |=> halted)
    else $error("Edge mode halt did not start.");
  a_fast_warmup: assert property (@(posedge sys_clk) disable iff (rst)
    warming && !target_slow_reg |-> clk_ctrl.fast_osc_on)
    else $error("Fast oscillator off for fast return.");
  a_warmup_hold: assert property (@(posedge sys_clk) disable iff (rst)
    warming |-> clk_ctrl.cpu_halt && clk_ctrl.wdt_halt && clk_ctrl.periph_gate)
    else $error("Operation resumed during warm-up.");
  a_count_step: assert property (@(posedge sys_clk) disable iff (rst)
    warming && tick && !count_done |=> count_reg == $past(count_reg) + 1'b1)
    else $error("Warm-up count did not advance.");

  c_edge_halt: cover property (@(posedge sys_clk) disable iff (rst)
    halted && !level_mode ##1 warming);
  c_level_halt: cover property (@(posedge sys_clk) disable iff (rst)
    halted && level_mode ##1 warming);
  c_flash_wait: cover property (@(posedge sys_clk) disable iff (rst)
    state_reg == PM_FLASH_WAIT ##1 state_reg == PM_RUN);
  c_level_skip: cover property (@(posedge sys_clk) disable iff (rst)
    halt_start ##1 warming);
  c_slow_return: cover property (@(posedge sys_clk) disable iff (rst)
    warming && target_slow_reg ##1 state_reg == PM_RUN);

endmodule : stop_mode_power_control

// ### stop_mode_wake_model.sv
`timescale 1ns/1ns
module stop_mode_wake_model (
  // Clock and oscillator state
  input  wire logic       sys_clk,
  input  wire logic       fast_on,
  input  wire logic       slow_on,
  // Wake pins and oscillator ticks
  output logic            release_pin_port,
  output logic [3:0]      key_wake_inputs,
  output logic            fast_tick,
  output logic            slow_tick
);
  logic [1:0] div_reg;

  initial begin
    release_pin_port = 1'b0;
    key_wake_inputs  = 4'hF;
    div_reg          = 2'h0;
    fast_tick        = 1'b0;
    slow_tick        = 1'b0;
  end

  // A stopped oscillator gives no ticks, so a missing restart stalls the warm-up.
  always @(posedge sys_clk) begin
    div_reg   <= div_reg + 2'h1;
    fast_tick <= fast_on & div_reg[0];
    slow_tick <= slow_on & (div_reg == 2'h3);
  end

  task automatic set_pin(input logic v);
    @(posedge sys_clk);
    release_pin_port <= v;
  endtask : set_pin

  task automatic set_keys(input logic [3:0] v);
    @(posedge sys_clk);
    key_wake_inputs <= v;
  endtask : set_keys
endmodule : stop_mode_wake_model

// ### stop_mode_power_control_tb_top.sv
`timescale 1ns/1ns
module stop_mode_power_control_tb_top import stop_mode_pkg::*;;
  logic       sys_clk, rst, fast_tick, slow_tick, release_pin_port;
  logic       halt_flash_wait_enable, idle_release, port_float, port_input_zero;
  logic       release_pin_float, pc_hold, soft_reset_req, seen;
  logic [3:0] key_wake_inputs, key_wake_control;
  logic [7:0] rdata;
  reg_req_t   req;
  clk_ctrl_t  clk_ctrl;
  int         n_errors, n_tests;

  stop_mode_power_control #(
    .WU_FAST_0_CYC(32'h0000_0018), .WU_FAST_1_CYC(32'h0000_0010),
    .WU_FAST_2_CYC(32'h0000_000C), .WU_FAST_3_CYC(32'h0000_0008),
    .WU_SLOW_0_CYC(32'h0000_000C), .WU_SLOW_1_CYC(32'h0000_0008),
    .WU_SLOW_2_CYC(32'h0000_0006), .WU_SLOW_3_CYC(32'h0000_0004)
  ) dut_u (
    .sys_clk(sys_clk), .rst(rst), .req(req), .rdata(rdata),
    .fast_tick(fast_tick), .slow_tick(slow_tick), .release_pin_port(release_pin_port),
    .key_wake_inputs(key_wake_inputs), .key_wake_control(key_wake_control),
    .halt_flash_wait_enable(halt_flash_wait_enable), .idle_release(idle_release),
    .clk_ctrl(clk_ctrl), .port_float(port_float), .port_input_zero(port_input_zero),
    .release_pin_float(release_pin_float), .pc_hold(pc_hold), .soft_reset_req(soft_reset_req)
  );

  stop_mode_wake_model wake_u (
    .sys_clk(sys_clk), .fast_on(clk_ctrl.fast_osc_on), .slow_on(clk_ctrl.slow_osc_on),
    .release_pin_port(release_pin_port), .key_wake_inputs(key_wake_inputs),
    .fast_tick(fast_tick), .slow_tick(slow_tick)
  );

  always #5 sys_clk = ~sys_clk;

  function automatic int wu(input int k);
    return (k == 0) ? 24 : (k == 1) ? 16 : (k == 2) ? 12 : 8;
  endfunction : wu

  task automatic report_and_stop();
    if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    req.wr <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string name);
    @(posedge sys_clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    req.rd <= 1'b0;
    #1 check(name, 16'(rdata), 16'(exp));
  endtask : rd_chk

  task automatic pulse_idle();
    @(posedge sys_clk);
    idle_release <= 1'b1;
    @(posedge sys_clk);
    idle_release <= 1'b0;
  endtask : pulse_idle

  task automatic halted(input logic keep);
    repeat (3) @(posedge sys_clk);
    #1 check("pc hold", 16'(pc_hold), 16'h0001);
    check("osc off", 16'({clk_ctrl.fast_osc_on, clk_ctrl.slow_osc_on}), 16'h0000);
    check("divider clear", 16'(clk_ctrl.tg_clear), 16'h0001);
    check("ports", 16'({port_float, port_input_zero, release_pin_float}), 16'({~keep, ~keep, 1'b1}));
  endtask : halted

  task automatic wait_run(input int lo, input int hi, input string name);
    int n;
    n = 0;
    while (pc_hold !== 1'b0 && n <= hi) begin
      @(posedge sys_clk);
      #1 n++;
    end
    check(name, 16'(n >= lo && n <= hi), 16'h0001);
  endtask : wait_run

  // The pin is high at entry, so only a fresh rising edge may end the halt.
  task automatic edge_halt(input logic [7:0] hc, input int per, input int n);
    wake_u.set_pin(1'b1);
    repeat (4) @(posedge sys_clk);
    wr(8'h38, hc);
    halted(hc[4]);
    repeat (20) @(posedge sys_clk);
    #1 check("still halted", 16'(pc_hold), 16'h0001);
    wake_u.set_pin(1'b0);
    repeat (4) @(posedge sys_clk);
    wake_u.set_pin(1'b1);
    wait_run(per * n - per, per * n + 12, "warm-up");
    wake_u.set_pin(1'b0);
    rd_chk(8'h38, hc & 8'h7C, "halt control");
  endtask : edge_halt

  initial begin
    #400_000;
    n_errors++;
    report_and_stop();
  end

  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    req = '0;
    key_wake_control = 4'h3;
    halt_flash_wait_enable = 1'b0;
    idle_release = 1'b0;
    n_errors = 0;
    n_tests = 0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    rd_chk(8'h38, 8'h00, "halt reset");
    rd_chk(8'h39, 8'h80, "clock reset");
    rd_chk(8'h3A, 8'h00, "unmapped");
    check("osc reset", 16'({clk_ctrl.fast_osc_on, clk_ctrl.slow_osc_on}), 16'h0002);
    wr(8'h38, 8'h4F);
    rd_chk(8'h38, 8'h4C, "low bits");
    wr(8'h39, 8'hEB);
    rd_chk(8'h39, 8'hE0, "clock mode");
    check("slow active", 16'(clk_ctrl.slow_clock_active), 16'h0001);
    wr(8'h39, 8'hC0);
    wr(8'h39, 8'hD0);
    #1 check("idle", 16'({clk_ctrl.cpu_halt, clk_ctrl.wdt_halt, clk_ctrl.periph_gate}), 16'h0006);
    pulse_idle();
    rd_chk(8'h39, 8'hC0, "idle clear");
    wr(8'h39, 8'hC4);
    #1 check("gate", 16'({clk_ctrl.cpu_halt, clk_ctrl.periph_gate}), 16'h0001);
    pulse_idle();
    rd_chk(8'h39, 8'hC0, "gate clear");
    for (int k = 0; k < 3; k++) begin
      wr(8'h39, (k == 0) ? 8'h00 : (k == 1) ? 8'h40 : 8'h80);
      seen = 1'b0;
      repeat (3) begin
        #1 seen |= soft_reset_req;
        @(posedge sys_clk);
      end
      check("self reset", 16'(seen), 16'(k != 2));
      wr(8'h39, 8'hC0);
    end
    wake_u.set_pin(1'b1);
    repeat (4) @(posedge sys_clk);
    wr(8'h38, 8'hCC);
    seen = 1'b1;
    repeat (30) begin
      @(posedge sys_clk);
      #1 seen &= clk_ctrl.fast_osc_on;
    end
    check("skip halt", 16'({seen, pc_hold}), 16'h0002);
    wake_u.set_pin(1'b0);
    repeat (4) @(posedge sys_clk);
    wr(8'h38, 8'hCC);
    halted(1'b0);
    wake_u.set_keys(4'h7);
    repeat (20) @(posedge sys_clk);
    #1 check("masked key", 16'(pc_hold), 16'h0001);
    @(posedge sys_clk);
    key_wake_control <= 4'h4;
    wake_u.set_keys(4'h3);
    wait_run(14, 28, "key wake");
    wake_u.set_keys(4'hF);
    repeat (4) @(posedge sys_clk);
    wr(8'h38, 8'hCC);
    halted(1'b0);
    wake_u.set_pin(1'b1);
    wait_run(14, 28, "pin level");
    wr(8'h38, 8'h0C);
    wr(8'h38, 8'h4C);
    wr(8'h38, 8'hCC);
    halted(1'b0);
    repeat (40) @(posedge sys_clk);
    #1 check("disarmed", 16'(pc_hold), 16'h0001);
    wake_u.set_pin(1'b0);
    repeat (4) @(posedge sys_clk);
    wake_u.set_pin(1'b1);
    wait_run(14, 28, "rearm");
    for (int k = 0; k < 4; k++) begin
      edge_halt(8'h80 | 8'(k << 2) | (k[0] ? 8'h10 : 8'h00), 2, wu(k));
      check("fast back", 16'(clk_ctrl.fast_osc_on), 16'h0001);
    end
    wr(8'h39, 8'hE0);
    for (int k = 0; k < 4; k++) begin
      edge_halt(8'hA0 | 8'(k << 2), 4, wu(k) / 2);
      check("slow back", 16'({clk_ctrl.fast_osc_on, clk_ctrl.slow_osc_on}), 16'h0001);
    end
    wr(8'h39, 8'hE0);
    wr(8'h39, 8'hC0);
    halt_flash_wait_enable <= 1'b1;
    edge_halt(8'h8C, 2, 8 + 1024);
    halt_flash_wait_enable <= 1'b0;
    wr(8'h39, 8'hE0);
    edge_halt(8'hAC, 4, 4);
    wake_u.set_pin(1'b1);
    repeat (4) @(posedge sys_clk);
    wr(8'h38, 8'hAC);
    halted(1'b0);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1 check("reset exit", 16'({clk_ctrl.fast_osc_on, clk_ctrl.slow_osc_on, pc_hold}), 16'h0004);
    rd_chk(8'h39, 8'h80, "reset mode");
    report_and_stop();
  end
endmodule : stop_mode_power_control_tb_top
